// File: pkg/line_host_pkg.sv
package line_host_pkg;

    // ****************************************
    // clock and widths
    // ****************************************
    localparam int unsigned CLK_NS = 5;
    localparam int unsigned CNT_W = 21;
    localparam int unsigned ADDR_W = 8;

    // ****************************************
    // documented limits, in their own units
    // ****************************************
    localparam int unsigned SLOT_MIN_US = 60;
    localparam int unsigned SLOT_MAX_US = 120;
    localparam int unsigned PROG_SUM_MAX_MS = 5;

    // ****************************************
    // chosen intervals, margin both sides
    // ****************************************
    localparam int unsigned SLOT_US = 70;
    localparam int unsigned W1_LOW_US = 6;
    localparam int unsigned W0_LOW_US = 65;
    localparam int unsigned RD_LOW_NS = 500;
    localparam int unsigned RD_SAMPLE_US = 12;
    localparam int unsigned REC_US = 5;
    localparam int unsigned RSTL_US = 500;
    localparam int unsigned RSTH_US = 500;
    localparam int unsigned PRES_SAMPLE_US = 70;
    localparam int unsigned DP_US = 10;
    localparam int unsigned DV_US = 10;
    localparam int unsigned PP_US = 500;

    // ****************************************
    // cycle counts, least times rounded up
    // ****************************************
    localparam logic [CNT_W-1:0] SLOT_CYC = CNT_W'((SLOT_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] W1_LOW_CYC = CNT_W'((W1_LOW_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] W0_LOW_CYC = CNT_W'((W0_LOW_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RD_LOW_CYC = CNT_W'((RD_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RD_SAMPLE_CYC = CNT_W'((RD_SAMPLE_US * 1000) / CLK_NS);
    localparam logic [CNT_W-1:0] REC_CYC = CNT_W'((REC_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RSTL_CYC = CNT_W'((RSTL_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RSTH_CYC = CNT_W'((RSTH_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] PRES_SAMPLE_CYC = CNT_W'((PRES_SAMPLE_US * 1000) / CLK_NS);
    localparam logic [CNT_W-1:0] DP_CYC = CNT_W'((DP_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] DV_CYC = CNT_W'((DV_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] PP_CYC = CNT_W'((PP_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] PROG_SUM_CYC = CNT_W'((PROG_SUM_MAX_MS * 1000000) / CLK_NS);

    // ****************************************
    // command and answer
    // ****************************************
    typedef enum logic [1:0] {
        OP_RESET,
        OP_WRITE,
        OP_READ,
        OP_PROGRAM
    } op_t;

    typedef struct packed {
        op_t op;
        logic bit_val;
        logic crc_ok;
        logic [ADDR_W-1:0] addr;
    } cmd_t;

    typedef struct packed {
        logic bit_val;
        logic presence;
        logic refused;
    } rsp_t;

endpackage : line_host_pkg

// File: logic/pin_sync.sv
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pin and filtered level
    input wire logic pin_i,
    output logic level_o
);

    logic s1_r, s2_r, s3_r, level_r;
    logic level_nxt;

    // a change counts only once the second and third stages agree
    always_comb begin
        level_nxt = level_r;
        if (s2_r == s3_r) begin
            level_nxt = s3_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= RESET_LEVEL;
            s2_r <= RESET_LEVEL;
            s3_r <= RESET_LEVEL;
            level_r <= RESET_LEVEL;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level_o = level_r;

endmodule : pin_sync

// File: logic/line_master.sv
module line_master #(
    parameter logic [line_host_pkg::CNT_W-1:0] SLOT_CYC_P = line_host_pkg::SLOT_CYC,
    parameter logic [line_host_pkg::CNT_W-1:0] W0_LOW_CYC_P = line_host_pkg::W0_LOW_CYC,
    parameter logic [line_host_pkg::CNT_W-1:0] RSTL_CYC_P = line_host_pkg::RSTL_CYC,
    parameter logic [line_host_pkg::CNT_W-1:0] RSTH_CYC_P = line_host_pkg::RSTH_CYC,
    parameter logic [line_host_pkg::CNT_W-1:0] PRES_CYC_P = line_host_pkg::PRES_SAMPLE_CYC,
    parameter logic [line_host_pkg::CNT_W-1:0] PP_CYC_P = line_host_pkg::PP_CYC,
    parameter logic [line_host_pkg::CNT_W-1:0] PROG_SUM_CYC_P = line_host_pkg::PROG_SUM_CYC
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // command
    input wire logic CMD_VALID_I,
    input wire line_host_pkg::cmd_t CMD_I,
    output logic CMD_READY_O,
    // answer
    output logic RSP_VALID_O,
    output line_host_pkg::rsp_t RSP_O,
    // data line, open drain
    input wire logic LINE_I,
    output logic LINE_O,
    output logic LINE_OE_O,
    // programming voltage switch
    output logic VPP_EN_O
);
    import line_host_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    localparam int unsigned ADDR_N = 1 << ADDR_W;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RST_LOW,
        ST_RST_HIGH,
        ST_SLOT,
        ST_RECOVER,
        ST_PRE_PROG,
        ST_PROG,
        ST_POST_PROG
    } state_t;

    state_t st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    cmd_t cmd_r, cmd_nxt;
    rsp_t rsp_r, rsp_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic line_oe_r, line_oe_nxt;
    logic vpp_r, vpp_nxt;
    logic line_s;
    logic [CNT_W-1:0] low_len;
    logic [CNT_W-1:0] acc_r [0:ADDR_N-1];
    logic acc_we;
    logic [CNT_W-1:0] acc_wval;
    logic [CNT_W:0] acc_sum;
    logic prog_room;

    // ****************************************
    // line input
    // ****************************************
    pin_sync #(
        .RESET_LEVEL(1'b1)
    ) u_line_sync (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .pin_i(LINE_I),
        .level_o(line_s)
    );

    // ****************************************
    // programming budget per address
    // ****************************************
    // new commands are checked against the stored sum before any pulse
    always_comb begin
        acc_sum = {1'b0, acc_r[CMD_I.addr]} + {1'b0, PP_CYC_P};
        prog_room = (acc_sum <= {1'b0, PROG_SUM_CYC_P});
        acc_wval = acc_r[cmd_r.addr] + PP_CYC_P;
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            for (int i = 0; i < ADDR_N; i++) begin
                acc_r[i] <= '0;
            end
        end else if (acc_we) begin
            acc_r[cmd_r.addr] <= acc_wval;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        if (cmd_r.op == OP_READ) begin
            low_len = RD_LOW_CYC;
        end else if (cmd_r.bit_val) begin
            low_len = W1_LOW_CYC;
        end else begin
            low_len = W0_LOW_CYC_P;
        end
    end

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r + 1'b1;
        cmd_nxt = cmd_r;
        rsp_nxt = rsp_r;
        rsp_valid_nxt = 1'b0;
        line_oe_nxt = line_oe_r;
        vpp_nxt = vpp_r;
        acc_we = 1'b0;
        case (st_r)
            ST_IDLE: begin
                cnt_nxt = '0;
                if (CMD_VALID_I) begin
                    cmd_nxt = CMD_I;
                    rsp_nxt = '0;
                    case (CMD_I.op)
                        OP_RESET: begin
                            st_nxt = ST_RST_LOW;
                            line_oe_nxt = 1'b1;
                        end
                        OP_WRITE, OP_READ: begin
                            st_nxt = ST_SLOT;
                            line_oe_nxt = 1'b1;
                        end
                        OP_PROGRAM: begin
                            if (CMD_I.crc_ok && prog_room) begin
                                st_nxt = ST_PRE_PROG;
                            end else begin
                                rsp_nxt.refused = 1'b1;
                                rsp_valid_nxt = 1'b1;
                            end
                        end
                        default: begin
                            st_nxt = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_RST_LOW: begin
                if (cnt_r == RSTL_CYC_P - 1'b1) begin
                    line_oe_nxt = 1'b0;
                    cnt_nxt = '0;
                    st_nxt = ST_RST_HIGH;
                end
            end
            ST_RST_HIGH: begin
                // device starts by 60 us and stays low at least 60 us
                if (cnt_r == PRES_CYC_P - 1'b1) begin
                    rsp_nxt.presence = ~line_s;
                end
                if (cnt_r == RSTH_CYC_P - 1'b1) begin
                    st_nxt = ST_IDLE;
                    rsp_valid_nxt = 1'b1;
                end
            end
            ST_SLOT: begin
                if (cnt_r == low_len - 1'b1) begin
                    line_oe_nxt = 1'b0;
                end
                // sampled inside the valid window, sync delay included
                if (cmd_r.op == OP_READ && cnt_r == RD_SAMPLE_CYC - 1'b1) begin
                    rsp_nxt.bit_val = line_s;
                end
                if (cnt_r == SLOT_CYC_P - 1'b1) begin
                    cnt_nxt = '0;
                    st_nxt = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (cnt_r == REC_CYC - 1'b1) begin
                    st_nxt = ST_IDLE;
                    rsp_valid_nxt = 1'b1;
                end
            end
            ST_PRE_PROG: begin
                if (cnt_r == DP_CYC - 1'b1) begin
                    vpp_nxt = 1'b1;
                    cnt_nxt = '0;
                    st_nxt = ST_PROG;
                end
            end
            ST_PROG: begin
                if (cnt_r == PP_CYC_P - 1'b1) begin
                    vpp_nxt = 1'b0;
                    acc_we = 1'b1;
                    cnt_nxt = '0;
                    st_nxt = ST_POST_PROG;
                end
            end
            ST_POST_PROG: begin
                if (cnt_r == DV_CYC - 1'b1) begin
                    st_nxt = ST_IDLE;
                    rsp_valid_nxt = 1'b1;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
                line_oe_nxt = 1'b0;
                vpp_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            st_r <= ST_IDLE;
            cnt_r <= '0;
            cmd_r <= '0;
            rsp_r <= '0;
            rsp_valid_r <= 1'b0;
            line_oe_r <= 1'b0;
            vpp_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            cmd_r <= cmd_nxt;
            rsp_r <= rsp_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            line_oe_r <= line_oe_nxt;
            vpp_r <= vpp_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // the line is only ever pulled low; high comes from the pull-up
    assign LINE_O = 1'b0;
    assign LINE_OE_O = line_oe_r;
    assign VPP_EN_O = vpp_r;
    assign CMD_READY_O = (st_r == ST_IDLE);
    assign RSP_VALID_O = rsp_valid_r;
    assign RSP_O = rsp_r;

    // ****************************************
    // checks
    // ****************************************
    logic [CNT_W-1:0] oe_run_r, oe_run_nxt;
    logic [CNT_W-1:0] hi_run_r, hi_run_nxt;
    logic [CNT_W-1:0] vpp_run_r, vpp_run_nxt;
    logic [CNT_W-1:0] post_vpp_r, post_vpp_nxt;

    // idle counters saturate so long gaps never wrap
    always_comb begin
        oe_run_nxt = line_oe_r ? oe_run_r + 1'b1 : '0;
        vpp_run_nxt = vpp_r ? vpp_run_r + 1'b1 : '0;
        hi_run_nxt = hi_run_r;
        if (line_oe_r || vpp_r) begin
            hi_run_nxt = '0;
        end else if (hi_run_r != '1) begin
            hi_run_nxt = hi_run_r + 1'b1;
        end
        post_vpp_nxt = post_vpp_r;
        if (vpp_r) begin
            post_vpp_nxt = '0;
        end else if (post_vpp_r != '1) begin
            post_vpp_nxt = post_vpp_r + 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            oe_run_r <= '0;
            hi_run_r <= '1;
            vpp_run_r <= '0;
            post_vpp_r <= '1;
        end else begin
            oe_run_r <= oe_run_nxt;
            hi_run_r <= hi_run_nxt;
            vpp_run_r <= vpp_run_nxt;
            post_vpp_r <= post_vpp_nxt;
        end
    end

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    sequence low_ends_s;
        $fell(line_oe_r);
    endsequence

    sequence refuse_answer_s;
        // the next command may already be taken in the answer cycle
        RSP_VALID_O && RSP_O.refused && CMD_READY_O ##1 !VPP_EN_O;
    endsequence

    slot_length_a: assert property (
        ($past(st_r) == ST_SLOT && st_r == ST_RECOVER) |-> $past(cnt_r) == SLOT_CYC_P - 1'b1
    ) else $error("slot length wrong");
    one_low_a: assert property (
        low_ends_s and (cmd_r.op == OP_WRITE && cmd_r.bit_val) |-> oe_run_r == W1_LOW_CYC
    ) else $error("write one low time wrong");
    zero_low_a: assert property (
        low_ends_s and (cmd_r.op == OP_WRITE && !cmd_r.bit_val) |-> oe_run_r == W0_LOW_CYC_P
    ) else $error("write zero low time wrong");
    read_low_a: assert property (
        low_ends_s and (cmd_r.op == OP_READ) |-> oe_run_r == RD_LOW_CYC
    ) else $error("read start low time wrong");
    recovery_gap_a: assert property (
        $rose(line_oe_r) |-> hi_run_r >= REC_CYC
    ) else $error("recovery gap too short");
    reset_low_a: assert property (
        low_ends_s and (cmd_r.op == OP_RESET) |-> oe_run_r == RSTL_CYC_P
    ) else $error("reset low time wrong");
    reset_high_a: assert property (
        ($past(st_r) == ST_RST_HIGH && st_r == ST_IDLE) |-> $past(cnt_r) == RSTH_CYC_P - 1'b1
    ) else $error("reset high wait wrong");
    pre_prog_a: assert property (
        $rose(vpp_r) |-> hi_run_r >= DP_CYC && !line_oe_r
    ) else $error("idle before programming too short");
    post_prog_a: assert property (
        $rose(line_oe_r) |-> post_vpp_r >= DV_CYC
    ) else $error("verify slot too soon after programming");
    prog_width_a: assert property (
        $fell(vpp_r) |-> vpp_run_r == PP_CYC_P
    ) else $error("programming pulse width wrong");
    prog_budget_a: assert property (
        $rose(vpp_r) |-> ({1'b0, acc_r[cmd_r.addr]} + {1'b0, PP_CYC_P}) <= {1'b0, PROG_SUM_CYC_P}
    ) else $error("programming budget exceeded");
    prog_check_a: assert property (
        (CMD_READY_O && CMD_VALID_I && CMD_I.op == OP_PROGRAM && !CMD_I.crc_ok)
            |=> refuse_answer_s
    ) else $error("unchecked byte was programmed");

endmodule : line_master

// File: dv/line_device_model.sv
module line_device_model #(
    parameter int PDH_CYC = 6000,
    parameter int PDL_CYC = 24000,
    parameter int RDV_CYC = 3000,
    parameter int SAMPLE_CYC = 6000,
    parameter int RST_DET_CYC = 96000
) (
    // clock
    input wire logic clk_i,
    // line and own pull-down
    input wire logic line_i,
    output logic drive_low_o,
    // scenario controls and written bit
    input wire logic present_i,
    input wire logic tx_en_i,
    input wire logic tx_bit_i,
    output logic rx_bit_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int drv_cnt = 0;
    int slot_cnt = 0;
    int low_cnt = 0;
    int pres_cnt = 0;
    logic prev_r = 1'b1;

    assign drive_low_o = (drv_cnt != 0);

    initial begin
        rx_bit_o = 1'b0;
    end

    // bench clock only paces the internal delays; the part itself has none
    always @(posedge clk_i) begin
        if (drv_cnt != 0) begin
            drv_cnt = drv_cnt - 1;
        end else begin
            if (prev_r && !line_i) begin
                slot_cnt = 1;
                if (tx_en_i && !tx_bit_i) begin
                    // zero held through the valid window, released at its end
                    drv_cnt = RDV_CYC;
                end
            end else if (slot_cnt != 0) begin
                slot_cnt = slot_cnt + 1;
            end
            if (slot_cnt == SAMPLE_CYC) begin
                rx_bit_o <= line_i;
            end
            if (!line_i) begin
                low_cnt = low_cnt + 1;
            end else begin
                // only a long low counts as reset; own drive is never counted
                if (!prev_r && low_cnt >= RST_DET_CYC && present_i) begin
                    pres_cnt = PDH_CYC;
                end
                low_cnt = 0;
            end
        end
        if (pres_cnt != 0) begin
            pres_cnt = pres_cnt - 1;
            if (pres_cnt == 0) begin
                drv_cnt = PDL_CYC;
            end
        end
        prev_r = line_i;
    end
endmodule : line_device_model

// File: dv/single_wire_slot_timing_tb.sv
module single_wire_slot_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import line_host_pkg::*;

    // ****************************************
    // shortened counts and unshortened package counts
    // ****************************************
    localparam int SLOT_P = 3000;
    localparam int W0_P = 2800;
    localparam int RSTL_P = 3000;
    localparam int RSTH_P = 8000;
    localparam int PRES_P = 3500;
    localparam int PP_P = 3000;
    localparam int SUM_P = 10000;
    localparam int W1_N = int'(W1_LOW_CYC);
    localparam int RD_N = int'(RD_LOW_CYC);
    localparam int REC_N = int'(REC_CYC);
    localparam int DP_N = int'(DP_CYC);
    localparam int DV_N = int'(DV_CYC);

    logic clk;
    logic rst;
    logic cmd_valid;
    cmd_t cmd;
    logic cmd_ready;
    logic rsp_valid;
    rsp_t rsp;
    logic line_o;
    logic line_oe;
    logic vpp_en;
    logic dev_low;
    logic present;
    logic tx_en;
    logic tx_bit;
    logic rx_bit;
    int lat;
    int oe_cnt;
    int vpp_cnt;
    int first_vpp;
    int ovl;
    int rdy_early;
    rsp_t rsp_got;
    int bad_count = 0;
    int checks = 0;

    // pull-up wins unless someone pulls low
    wire line_w = ~(line_oe & ~line_o) & ~dev_low;

    line_master #(
        .SLOT_CYC_P(CNT_W'(SLOT_P)),
        .W0_LOW_CYC_P(CNT_W'(W0_P)),
        .RSTL_CYC_P(CNT_W'(RSTL_P)),
        .RSTH_CYC_P(CNT_W'(RSTH_P)),
        .PRES_CYC_P(CNT_W'(PRES_P)),
        .PP_CYC_P(CNT_W'(PP_P)),
        .PROG_SUM_CYC_P(CNT_W'(SUM_P))
    ) line_master_inst (
        .CLK_SYS_I(clk),
        .RST_I(rst),
        .CMD_VALID_I(cmd_valid),
        .CMD_I(cmd),
        .CMD_READY_O(cmd_ready),
        .RSP_VALID_O(rsp_valid),
        .RSP_O(rsp),
        .LINE_I(line_w),
        .LINE_O(line_o),
        .LINE_OE_O(line_oe),
        .VPP_EN_O(vpp_en)
    );

    line_device_model #(
        .PDH_CYC(2000),
        .PDL_CYC(4000),
        .RDV_CYC(3000),
        .SAMPLE_CYC(2000),
        .RST_DET_CYC(2900)
    ) line_device_model_inst (
        .clk_i(clk),
        .line_i(line_w),
        .drive_low_o(dev_low),
        .present_i(present),
        .tx_en_i(tx_en),
        .tx_bit_i(tx_bit),
        .rx_bit_o(rx_bit)
    );

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // called at a falling edge; returns at the falling edge of the answer cycle
    task automatic run_cmd(input op_t op, input logic bv, input logic ok, input logic [7:0] ad);
        int k;
        k = 0;
        oe_cnt = 0;
        vpp_cnt = 0;
        first_vpp = 0;
        ovl = 0;
        rdy_early = 0;
        while (cmd_ready !== 1'b1) @(negedge clk);
        cmd_valid = 1'b1;
        cmd = '{op: op, bit_val: bv, crc_ok: ok, addr: ADDR_W'(ad)};
        @(negedge clk);
        cmd_valid = 1'b0;
        forever begin
            k++;
            if (line_oe === 1'b1) oe_cnt++;
            if (line_oe === 1'b1 && vpp_en === 1'b1) ovl++;
            if (cmd_ready === 1'b1 && rsp_valid !== 1'b1) rdy_early++;
            if (vpp_en === 1'b1) begin
                if (first_vpp == 0) first_vpp = k;
                vpp_cnt++;
            end
            if (rsp_valid === 1'b1 || k > 20000) break;
            @(negedge clk);
        end
        lat = k;
        rsp_got = rsp;
    endtask : run_cmd

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset();
        for (int p = 1; p >= 0; p--) begin
            present = p[0];
            run_cmd(OP_RESET, 1'b0, 1'b0, 8'h00);
            check(oe_cnt, RSTL_P);
            check(lat, RSTL_P + RSTH_P + 1);
            check(rdy_early, 0);
            check(32'(rsp_got.presence), p);
        end
        present = 1'b1;
    endtask : test_reset

    // back to back: each command is offered in the previous answer cycle
    task automatic test_write();
        for (int b = 0; b < 2; b++) begin
            run_cmd(OP_WRITE, b[0], 1'b0, 8'h00);
            check(oe_cnt, (b == 1) ? W1_N : W0_P);
            check(lat, SLOT_P + REC_N + 1);
            check(rdy_early, 0);
            check(32'(rx_bit), b);
        end
    endtask : test_write

    task automatic test_read();
        tx_en = 1'b1;
        for (int b = 0; b < 2; b++) begin
            tx_bit = b[0];
            run_cmd(OP_READ, 1'b0, 1'b0, 8'h00);
            check(oe_cnt, RD_N);
            check(32'(line_o), 0);
            check(32'(rsp_got.bit_val), b);
            check(lat, SLOT_P + REC_N + 1);
        end
        tx_en = 1'b0;
    endtask : test_read

    // third pulse on one address fills the budget, the fourth must be refused
    task automatic test_program();
        logic ok;
        run_cmd(OP_PROGRAM, 1'b0, 1'b0, 8'h05);
        check(lat, 1);
        check(vpp_cnt, 0);
        check(32'(rsp_got.refused), 1);
        check(32'(cmd_ready), 1);
        for (int n = 0; n < 5; n++) begin
            ok = (n != 3);
            run_cmd(OP_PROGRAM, 1'b0, 1'b1, (n == 4) ? 8'h06 : 8'h05);
            check(32'(rsp_got.refused), 32'(!ok));
            check(vpp_cnt, ok ? PP_P : 0);
            if (ok) begin
                check(first_vpp, DP_N + 1);
                check(lat, DP_N + PP_P + DV_N + 1);
                check(ovl, 0);
                check(rdy_early, 0);
            end
        end
        // verify slot right after the last pulse
        tx_en = 1'b1;
        tx_bit = 1'b0;
        run_cmd(OP_READ, 1'b0, 1'b0, 8'h00);
        check(32'(rsp_got.bit_val), 0);
        check(lat, SLOT_P + REC_N + 1);
        tx_en = 1'b0;
    endtask : test_program

    // ****************************************
    // clock, sequence, watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        present = 1'b1;
        tx_en = 1'b0;
        tx_bit = 1'b0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        test_reset();
        test_write();
        test_read();
        test_program();
        print_verdict();
    end

    // whole run needs about 70000 cycles
    initial begin
        #600000;
        bad_count++;
        print_verdict();
    end
endmodule : single_wire_slot_timing_tb
